// >>> common/axi_probe_pkg.sv
// shared types and constants for the axi channel trigger probe
// assumes a single monitored interface clock; no software registers
package axi_probe_pkg;

    // probe bit positions
    localparam int VALID_BIT = 0;
    localparam int READY_BIT = 1;
    localparam int LAST_BIT  = 2;

    // probe widths
    localparam int ADDR_PROBE_W = 2;
    localparam int DATA_PROBE_W = 3;

    // event match codes
    localparam logic [1:0] ADDR_CMD_END  = 2'h3;
    localparam logic [2:0] LAST_BEAT_END = 3'h7;
    localparam logic [2:0] MID_BEAT_END  = 3'h3;
    localparam logic [1:0] RESP_END      = 2'h3;

    // reset values
    localparam logic [1:0] ADDR_PROBE_RST = 2'h0;
    localparam logic [2:0] DATA_PROBE_RST = 3'h0;

    // number of decoded events, and their positions in the event vector
    localparam int NUM_EVENTS    = 7;
    localparam int EV_AR_CMD     = 0;
    localparam int EV_R_LAST     = 1;
    localparam int EV_R_BEAT     = 2;
    localparam int EV_AW_CMD     = 3;
    localparam int EV_W_LAST     = 4;
    localparam int EV_W_BEAT     = 5;
    localparam int EV_B_RESP     = 6;

    localparam logic [NUM_EVENTS-1:0] EVENT_RST = 7'h00;

    // raw handshake inputs of all five channels
    typedef struct packed {
        logic arvalid;
        logic arready;
        logic rvalid;
        logic rready;
        logic rlast;
        logic awvalid;
        logic awready;
        logic wvalid;
        logic wready;
        logic wlast;
        logic bvalid;
        logic bready;
    } axi_handshake_t;

    // packed per-channel probes
    typedef struct packed {
        logic [ADDR_PROBE_W-1:0] read_addr;
        logic [DATA_PROBE_W-1:0] read_data;
        logic [ADDR_PROBE_W-1:0] write_addr;
        logic [DATA_PROBE_W-1:0] write_data;
        logic [ADDR_PROBE_W-1:0] write_resp;
    } channel_probes_t;

endpackage

// >>> core/probe_event_decode.sv
// decodes handshake events from the packed channel probes
// assumes probes are registered on the same clock; purely combinational
`timescale 1ns/1ps
module probe_event_decode
    import axi_probe_pkg::*;
(
    input  wire axi_probe_pkg::channel_probes_t          probes_in,
    output logic [axi_probe_pkg::NUM_EVENTS-1:0]         events_out
);
    import axi_probe_pkg::*;

    always_comb
    begin
        events_out              = EVENT_RST;
        events_out[EV_AR_CMD]   = (probes_in.read_addr  == ADDR_CMD_END);
        events_out[EV_R_LAST]   = (probes_in.read_data  == LAST_BEAT_END);
        events_out[EV_R_BEAT]   = (probes_in.read_data  == MID_BEAT_END);
        events_out[EV_AW_CMD]   = (probes_in.write_addr == ADDR_CMD_END);
        events_out[EV_W_LAST]   = (probes_in.write_data == LAST_BEAT_END);
        events_out[EV_W_BEAT]   = (probes_in.write_data == MID_BEAT_END);
        events_out[EV_B_RESP]   = (probes_in.write_resp == RESP_END);
    end

endmodule

// >>> core/axi_channel_trigger_probe.sv
// axi channel trigger probe: packs handshake signals per channel, decodes
// end-of-command, end-of-beat and response events, ors selected ones into a trigger
// assumes the handshake inputs come from logic on clk_in (no synchroniser needed)
`timescale 1ns/1ps

// Functional notes
// - read address probe is two bits: valid bit 0, ready bit 1, both registered in the same cycle.
// - read data probe is three bits: valid bit 0, ready bit 1, last bit 2.
// - write address probe is two bits: valid bit 0, ready bit 1.
// - write data probe is three bits: valid bit 0, ready bit 1, last bit 2.
// - write response probe is two bits: valid bit 0, ready bit 1.
// - flag read address command end when its probe equals 2'b11.
// - flag last read beat end when read data probe equals 3'b111.
// - flag non-last read beat end when read data probe equals 3'b011.
// - flag write address command end when its probe equals 2'b11.
// - flag last write beat end when write data probe equals 3'b111.
// - flag non-last write beat end when write data probe equals 3'b011.
// - selected per-channel events are ored into one trigger condition.
// - flag write response when response probe equals 2'b11.
module axi_channel_trigger_probe
    import axi_probe_pkg::*;
(
    input  wire logic                                    clk_in,
    input  wire logic                                    rst_b_in,
    input  wire logic                                    clk_en_in,
    input  wire axi_probe_pkg::axi_handshake_t           handshake_in,
    input  wire logic [axi_probe_pkg::NUM_EVENTS-1:0]    trigger_select_in,
    input  wire logic [axi_probe_pkg::NUM_EVENTS-1:0]    capture_select_in,
    output logic [axi_probe_pkg::ADDR_PROBE_W-1:0]       read_addr_handshake_probe_out,
    output logic [axi_probe_pkg::DATA_PROBE_W-1:0]       read_data_handshake_probe_out,
    output logic [axi_probe_pkg::ADDR_PROBE_W-1:0]       write_addr_handshake_probe_out,
    output logic [axi_probe_pkg::DATA_PROBE_W-1:0]       write_data_handshake_probe_out,
    output logic [axi_probe_pkg::ADDR_PROBE_W-1:0]       write_resp_handshake_probe_out,
    output logic [axi_probe_pkg::NUM_EVENTS-1:0]         events_out,
    output logic                                         trigger_out,
    output logic                                         capture_out
);
    import axi_probe_pkg::*;

    // ============================================================
    // reset release
    // ============================================================
    logic            rst_sync_a;
    logic            rst_sync_b;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_sync_a <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_sync_a <= 1'b1;
            rst_sync_b <= rst_sync_a;
        end
    end

    // ============================================================
    // probe packing
    // ============================================================
    channel_probes_t next_probes;
    channel_probes_t probes;

    always_comb
    begin
        next_probes = '0;
        next_probes.read_addr[VALID_BIT]  = handshake_in.arvalid;
        next_probes.read_addr[READY_BIT]  = handshake_in.arready;
        next_probes.read_data[VALID_BIT]  = handshake_in.rvalid;
        next_probes.read_data[READY_BIT]  = handshake_in.rready;
        next_probes.read_data[LAST_BIT]   = handshake_in.rlast;
        next_probes.write_addr[VALID_BIT] = handshake_in.awvalid;
        next_probes.write_addr[READY_BIT] = handshake_in.awready;
        next_probes.write_data[VALID_BIT] = handshake_in.wvalid;
        next_probes.write_data[READY_BIT] = handshake_in.wready;
        next_probes.write_data[LAST_BIT]  = handshake_in.wlast;
        next_probes.write_resp[VALID_BIT] = handshake_in.bvalid;
        next_probes.write_resp[READY_BIT] = handshake_in.bready;
    end

    // ============================================================
    // read address channel probe
    // ============================================================
    logic [ADDR_PROBE_W-1:0] read_addr_probe;

    always_ff @(posedge clk_in or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            read_addr_probe <= ADDR_PROBE_RST;
        end
        else if (clk_en_in)
        begin
            read_addr_probe <= next_probes.read_addr;
        end
    end

    assign read_addr_handshake_probe_out = read_addr_probe;

    // ============================================================
    // read data channel probe
    // ============================================================
    logic [DATA_PROBE_W-1:0] read_data_probe;

    always_ff @(posedge clk_in or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            read_data_probe <= DATA_PROBE_RST;
        end
        else if (clk_en_in)
        begin
            read_data_probe <= next_probes.read_data;
        end
    end

    assign read_data_handshake_probe_out = read_data_probe;

    // ============================================================
    // write address channel probe
    // ============================================================
    logic [ADDR_PROBE_W-1:0] write_addr_probe;

    always_ff @(posedge clk_in or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            write_addr_probe <= ADDR_PROBE_RST;
        end
        else if (clk_en_in)
        begin
            write_addr_probe <= next_probes.write_addr;
        end
    end

    assign write_addr_handshake_probe_out = write_addr_probe;

    // ============================================================
    // write data channel probe
    // ============================================================
    logic [DATA_PROBE_W-1:0] write_data_probe;

    always_ff @(posedge clk_in or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            write_data_probe <= DATA_PROBE_RST;
        end
        else if (clk_en_in)
        begin
            write_data_probe <= next_probes.write_data;
        end
    end

    assign write_data_handshake_probe_out = write_data_probe;

    // ============================================================
    // write response channel probe
    // ============================================================
    logic [ADDR_PROBE_W-1:0] write_resp_probe;

    always_ff @(posedge clk_in or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            write_resp_probe <= ADDR_PROBE_RST;
        end
        else if (clk_en_in)
        begin
            write_resp_probe <= next_probes.write_resp;
        end
    end

    assign write_resp_handshake_probe_out = write_resp_probe;

    // ============================================================
    // probe recombination for the event decoder
    // ============================================================
    // every channel register shares one edge and enable, so the decoder
    // always sees one coherent cycle of all five handshakes
    always_comb
    begin
        probes            = '0;
        probes.read_addr  = read_addr_probe;
        probes.read_data  = read_data_probe;
        probes.write_addr = write_addr_probe;
        probes.write_data = write_data_probe;
        probes.write_resp = write_resp_probe;
    end

    // ============================================================
    // event decode
    // ============================================================
    logic [NUM_EVENTS-1:0] decoded;

    probe_event_decode u_decode
    (
        .probes_in  (probes),
        .events_out (decoded)
    );

    assign events_out = decoded;

    // ============================================================
    // trigger and capture conditions
    // ============================================================
    // sum of products across channels, each term a whole-probe compare
    logic [NUM_EVENTS-1:0] trigger_terms;
    logic [NUM_EVENTS-1:0] capture_terms;

    for (genvar e = 0; e < NUM_EVENTS; e++)
    begin : g_select_terms
        assign trigger_terms[e] = decoded[e] & trigger_select_in[e];
        assign capture_terms[e] = decoded[e] & capture_select_in[e];
    end

    assign trigger_out = |trigger_terms;
    assign capture_out = |capture_terms;

endmodule

// >>> tb/axi_peer_model.sv
// far side model: master and slave handshake levels seen by the probe
// assumes the bench sets cmd_in at the falling edge; stall_in holds every ready low
`timescale 1ns/1ps
module axi_peer_model
    import axi_probe_pkg::*;
(
    input  wire logic [11:0]                 cmd_in,
    input  wire logic                        stall_in,
    output axi_probe_pkg::axi_handshake_t    handshake_out
);
    // a slow slave withholds ready on all five channels
    assign handshake_out = stall_in ? (cmd_in & ~12'h529) : cmd_in;
endmodule

// >>> tb/probe_properties.sv
// checker of the channel probe, bound to its top module
// assumes one clock, clk_in, and the two-flop reset release
`timescale 1ns/1ps
module probe_properties
    import axi_probe_pkg::*;
(
    input wire logic                           clk_in,
    input wire logic                           rst_b_in,
    input wire logic                           clk_en_in,
    input wire axi_probe_pkg::axi_handshake_t  handshake_in,
    input wire logic [6:0]                     trigger_select_in,
    input wire logic [6:0]                     capture_select_in,
    input wire logic [1:0]                     read_addr_handshake_probe_out,
    input wire logic [2:0]                     read_data_handshake_probe_out,
    input wire logic [1:0]                     write_addr_handshake_probe_out,
    input wire logic [2:0]                     write_data_handshake_probe_out,
    input wire logic [1:0]                     write_resp_handshake_probe_out,
    input wire logic [6:0]                     events_out,
    input wire logic                           trigger_out,
    input wire logic                           capture_out
);
    logic [1:0]  up;
    logic [11:0] want;
    logic [11:0] seen;
    assign want = {handshake_in.arready, handshake_in.arvalid,
        handshake_in.rlast, handshake_in.rready, handshake_in.rvalid,
        handshake_in.awready, handshake_in.awvalid,
        handshake_in.wlast, handshake_in.wready, handshake_in.wvalid,
        handshake_in.bready, handshake_in.bvalid};
    assign seen = {read_addr_handshake_probe_out, read_data_handshake_probe_out,
        write_addr_handshake_probe_out, write_data_handshake_probe_out,
        write_resp_handshake_probe_out};
    // counts edges since release, so samples ignored by the reset flops are skipped
    always_ff @(posedge clk_in or negedge rst_b_in)
        if (!rst_b_in) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_live; (up == 2'h3) && $past(clk_en_in); endsequence
    sequence s_held; (up == 2'h3) && !$past(clk_en_in); endsequence
    property p_packing; s_live |-> seen == $past(want); endproperty
    // ==========================================
    // assertions
    chk_probe_packing: assert property (p_packing)
        else $error("probe packing wrong");
    chk_probe_frozen: assert property (s_held |-> $stable(seen) && $stable(events_out))
        else $error("probes moved while disabled");
    chk_addr_events: assert property (events_out[0] == (seen[11:10] == 2'h3)
        && events_out[3] == (seen[6:5] == 2'h3)) else $error("address event wrong");
    chk_rdata_events: assert property (events_out[2:1] ==
        {seen[9:7] == 3'h3, seen[9:7] == 3'h7}) else $error("read beat event wrong");
    chk_wdata_events: assert property (events_out[5:4] ==
        {seen[4:2] == 3'h3, seen[4:2] == 3'h7}) else $error("write beat event wrong");
    chk_resp_event: assert property (events_out[6] == (seen[1:0] == 2'h3))
        else $error("response event wrong");
    chk_trigger_or: assert property (trigger_out == |(events_out & trigger_select_in))
        else $error("trigger wrong");
    chk_capture_or: assert property (capture_out == |(events_out & capture_select_in))
        else $error("capture wrong");
endmodule

// >>> tb/testbench.sv
// self-checking bench of the channel probe
// assumes the probe and peer model compiled before it
`timescale 1ns/1ps
module testbench;
    import axi_probe_pkg::*;
    logic clk_in = 1'b0, rst_b_in = 1'b0, clk_en_in = 1'b1, stall = 1'b0, trig, capt;
    logic [11:0] cmd = 12'h000;
    logic [6:0] tsel = 7'h00, csel = 7'h00, ev;
    logic [1:0] ra, wa, wr;
    logic [2:0] rd, wd;
    axi_handshake_t hs;
    int mismatches = 0, n_compared = 0, cycles = 0;
    int pmap[12] = '{1, 0, 4, 3, 2, 6, 5, 9, 8, 7, 11, 10};
    logic [11:0] pat[9] = '{12'hC00, 12'h380, 12'h300, 12'h060, 12'h01C, 12'h018,
        12'h003, 12'h280, 12'hFFF};
    logic [6:0] evx[9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00, 7'h5B};
    always #2 clk_in = ~clk_in;
    axi_peer_model i_axi_peer_model (.cmd_in(cmd), .stall_in(stall), .handshake_out(hs));
    axi_channel_trigger_probe i_axi_channel_trigger_probe (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in), .handshake_in(hs), .trigger_select_in(tsel), .capture_select_in(csel),
        .read_addr_handshake_probe_out(ra), .read_data_handshake_probe_out(rd),
        .write_addr_handshake_probe_out(wa), .write_data_handshake_probe_out(wd),
        .write_resp_handshake_probe_out(wr), .events_out(ev), .trigger_out(trig),
        .capture_out(capt));
    // ==========================================
    // compare, drive and scenarios
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic drive(input logic [11:0] h);
        @(negedge clk_in) cmd = h;
        @(negedge clk_in);
    endtask
    task automatic t_packing;
        for (int i = 0; i < 12; i++)
        begin
            drive(12'h001 << i);
            cmp({ra, rd, wa, wd, wr}, 12'h001 << pmap[i]);
        end
    endtask
    task automatic t_events;
        for (int k = 0; k < 9; k++)
        begin
            tsel = evx[k];
            csel = ~evx[k];
            drive(pat[k]);
            cmp({5'h00, ev}, {5'h00, evx[k]});
            cmp({10'h000, trig, capt}, {10'h000, evx[k] != 7'h00, 1'b0});
        end
        tsel = 7'h09;
        csel = 7'h48;
        drive(12'h060);
        cmp({10'h000, trig, capt}, 12'h003);
    endtask
    task automatic t_freeze_and_stall;
        drive(12'hC00);
        clk_en_in = 1'b0;
        drive(12'h003);
        cmp({ra, rd, wa, wd, wr}, 12'hC00);
        cmp({5'h00, ev}, 12'h001);
        clk_en_in = 1'b1;
        stall = 1'b1;
        drive(12'hFFF);
        cmp({5'h00, ev}, 12'h000);
        stall = 1'b0;
    endtask
    task automatic t_reset;
        @(negedge clk_in) rst_b_in = 1'b0;
        #1;
        cmp({ra, rd, wa, wd, wr}, 12'h000);
        @(negedge clk_in) rst_b_in = 1'b1;
        repeat (4) @(negedge clk_in);
        cmp({ra, rd, wa, wd, wr}, 12'hFFF);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in) rst_b_in = 1'b1;
        repeat (3) @(negedge clk_in);
        t_packing();
        t_events();
        t_freeze_and_stall();
        t_reset();
        tally_and_finish();
    end
endmodule
bind axi_channel_trigger_probe probe_properties i_probe_properties (.clk_in, .rst_b_in,
    .clk_en_in, .handshake_in, .trigger_select_in, .capture_select_in,
    .read_addr_handshake_probe_out, .read_data_handshake_probe_out,
    .write_addr_handshake_probe_out, .write_data_handshake_probe_out,
    .write_resp_handshake_probe_out, .events_out, .trigger_out, .capture_out);
